// [logic/bkptd_tamper_detect.sv]
`timescale 1ns/1ns
// synchronises the tamper pin and flags the active level
module bkptd_tamper_detect (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_tamper_pin,
  input wire logic i_tamper_detect_enable,
  input wire logic i_tamper_active_level,
  output logic o_hit
);
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic level_reg;
  logic hit_reg;

  //------------------------------------------------------------------
  // three-stage synchroniser
  //------------------------------------------------------------------
  // stage one feeds only stage two, keeping metastability contained
  // reset parks the chain at the active level, so a system reset with detection on fakes an event
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      sync1_reg <= ~i_tamper_active_level;
      sync2_reg <= ~i_tamper_active_level;
      sync3_reg <= ~i_tamper_active_level;
    end else begin
      sync1_reg <= i_tamper_pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // accept a new level only when stages two and three agree
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      level_reg <= ~i_tamper_active_level;
    end else if (sync2_reg == sync3_reg) begin
      level_reg <= sync3_reg;
    end
  end

  // level mode: a pin held active keeps hitting every cycle
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      hit_reg <= 1'b0;
    end else begin
      hit_reg <= i_tamper_detect_enable & (level_reg ^ i_tamper_active_level);
    end
  end

  assign o_hit = hit_reg;
endmodule

// [logic/bkptd_top.sv]
`timescale 1ns/1ns
`include "bkptd_cfg.svh"
// backup word bank with tamper detection, apb slave
module bkptd_top (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_standby_wake,
  input wire logic i_backup_domain_soft_reset,
  input wire logic i_supply_return,
  input wire logic i_tamper_pin,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_tamper_irq,
  output logic o_tamper_detect_enable
);
  bkptd_pkg::bkptd_word_type data_reg [`BKPTD_WORDS];
  logic [`BKPTD_WORDS-1:0] data_hit;
  logic tamper_detect_enable_reg;
  logic tamper_active_level_reg;
  logic tamper_event_flag_reg;
  logic tamper_irq_flag_reg;
  logic tamper_irq_enable_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic detector_hit;
  logic spurious_event;
  logic tamper_event;
  logic backup_domain_rst;
  logic sys_rst;
  logic setup_phase;
  logic write_done;
  logic [`BKPTD_ADDR_W-1:0] addr;
  logic high_addr_zero;
  logic wr_ctrl;
  logic wr_csts;
  bkptd_pkg::bkptd_sel_type sel;
  bkptd_pkg::bkptd_word_type word_rd;

  //------------------------------------------------------------------
  // reset sources
  //------------------------------------------------------------------
  // backup domain reset is separate from the system reset on purpose
  assign backup_domain_rst = i_backup_domain_soft_reset | i_supply_return;
  // irq state follows the system, not the backup domain
  assign sys_rst = i_srst | i_standby_wake;

  //------------------------------------------------------------------
  // address decode
  //------------------------------------------------------------------
  assign addr = i_paddr[`BKPTD_ADDR_W-1:0];
  assign high_addr_zero = (i_paddr[31:`BKPTD_ADDR_W] == 24'h000000) && (i_paddr[1:0] == 2'h0);

  // one comparator per word; the map has a gap around the control pair
  genvar gi;
  generate
    for (gi = 0; gi < `BKPTD_WORDS; gi++) begin : g_dec
      localparam logic [`BKPTD_ADDR_W-1:0] WORD_ADDR = (gi < `BKPTD_LO_WORDS) ?
        8'(`BKPTD_DATA_LO_BASE + 4 * gi) :
        8'(`BKPTD_DATA_HI_BASE + 4 * (gi - `BKPTD_LO_WORDS));
      assign data_hit[gi] = high_addr_zero && (addr == WORD_ADDR);
    end
  endgenerate

  // register select and payload read mux
  always_comb begin
    sel = bkptd_pkg::BKPTD_SEL_NONE;
    word_rd = `BKPTD_WORD_RESET;
    for (int k = 0; k < `BKPTD_WORDS; k++) begin
      if (data_hit[k]) begin
        sel = bkptd_pkg::BKPTD_SEL_DATA;
        word_rd = data_reg[k];
      end
    end
    if (high_addr_zero && addr == `BKPTD_CTRL_OFFSET) begin
      sel = bkptd_pkg::BKPTD_SEL_CTRL;
    end
    if (high_addr_zero && addr == `BKPTD_CSTS_OFFSET) begin
      sel = bkptd_pkg::BKPTD_SEL_CSTS;
    end
  end

  //------------------------------------------------------------------
  // apb handshake
  //------------------------------------------------------------------
  // every transfer takes exactly one access cycle
  assign setup_phase = i_psel & ~i_penable;
  assign write_done = i_psel & i_penable & pready_reg & i_pwrite & ~pslverr_reg;
  assign wr_ctrl = write_done && sel == bkptd_pkg::BKPTD_SEL_CTRL;
  assign wr_csts = write_done && sel == bkptd_pkg::BKPTD_SEL_CSTS;

  // read data built from the current state; clear bits always read 0
  always_comb begin
    prdata_next = 32'h00000000;
    unique case (sel)
      bkptd_pkg::BKPTD_SEL_NONE: prdata_next = 32'h00000000;
      bkptd_pkg::BKPTD_SEL_DATA: prdata_next[15:0] = word_rd;
      bkptd_pkg::BKPTD_SEL_CTRL: begin
        prdata_next[`BKPTD_CTRL_EN_BIT] = tamper_detect_enable_reg;
        prdata_next[`BKPTD_CTRL_ALEV_BIT] = tamper_active_level_reg;
      end
      bkptd_pkg::BKPTD_SEL_CSTS: begin
        prdata_next[`BKPTD_CSTS_IRQ_EN_BIT] = tamper_irq_enable_reg;
        prdata_next[`BKPTD_CSTS_EVENT_FLAG_BIT] = tamper_event_flag_reg;
        prdata_next[`BKPTD_CSTS_IRQ_FLAG_BIT] = tamper_irq_flag_reg;
      end
    endcase
  end

  // answer prepared in the setup cycle so outputs stay registered
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= setup_phase;
      if (setup_phase) begin
        pslverr_reg <= (sel == bkptd_pkg::BKPTD_SEL_NONE);
        prdata_reg <= i_pwrite ? 32'h00000000 : prdata_next;
      end else begin
        pslverr_reg <= 1'b0;
        prdata_reg <= 32'h00000000;
      end
    end
  end

  //------------------------------------------------------------------
  // tamper detection
  //------------------------------------------------------------------
  bkptd_tamper_detect u_detect (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_tamper_pin(i_tamper_pin),
    .i_tamper_detect_enable(tamper_detect_enable_reg),
    .i_tamper_active_level(tamper_active_level_reg),
    .o_hit(detector_hit)
  );

  // dropping both control bits at once fakes an event, like the original
  assign spurious_event = wr_ctrl && tamper_detect_enable_reg && tamper_active_level_reg &&
    i_pwdata[1:0] == 2'h0;
  assign tamper_event = detector_hit | spurious_event;

  //------------------------------------------------------------------
  // control register, backup domain
  //------------------------------------------------------------------
  // reserved bits are not stored; software should keep them zero
  always_ff @(posedge i_clock) begin
    if (backup_domain_rst) begin
      tamper_detect_enable_reg <= `BKPTD_BIT_RESET;
      tamper_active_level_reg <= `BKPTD_BIT_RESET;
    end else if (wr_ctrl) begin
      tamper_detect_enable_reg <= i_pwdata[`BKPTD_CTRL_EN_BIT];
      tamper_active_level_reg <= i_pwdata[`BKPTD_CTRL_ALEV_BIT];
    end
  end

  //------------------------------------------------------------------
  // event flag, backup domain
  //------------------------------------------------------------------
  // a hit in the clear cycle wins, so a still-active pin re-raises it
  always_ff @(posedge i_clock) begin
    if (backup_domain_rst) begin
      tamper_event_flag_reg <= `BKPTD_BIT_RESET;
    end else if (tamper_event) begin
      tamper_event_flag_reg <= 1'b1;
    end else if (wr_csts && i_pwdata[`BKPTD_CSTS_CLR_EVENT_BIT]) begin
      tamper_event_flag_reg <= 1'b0;
    end
  end

  //------------------------------------------------------------------
  // irq enable and irq flag, system domain
  //------------------------------------------------------------------
  // enable is plain read-write state; a backup domain reset leaves it alone
  always_ff @(posedge i_clock) begin
    if (sys_rst) begin
      tamper_irq_enable_reg <= `BKPTD_BIT_RESET;
    end else if (wr_csts) begin
      tamper_irq_enable_reg <= i_pwdata[`BKPTD_CSTS_IRQ_EN_BIT];
    end
  end

  // flag needs detection enabled too; set beats either kind of clear
  always_ff @(posedge i_clock) begin
    if (sys_rst) begin
      tamper_irq_flag_reg <= `BKPTD_BIT_RESET;
    end else if (tamper_event && tamper_irq_enable_reg && tamper_detect_enable_reg) begin
      tamper_irq_flag_reg <= 1'b1;
    end else if (wr_csts && i_pwdata[`BKPTD_CSTS_CLR_IRQ_BIT]) begin
      tamper_irq_flag_reg <= 1'b0;
    end else if (wr_csts && !i_pwdata[`BKPTD_CSTS_IRQ_EN_BIT]) begin
      tamper_irq_flag_reg <= 1'b0;
    end
  end

  //------------------------------------------------------------------
  // backup words
  //------------------------------------------------------------------
  // only backup domain reset or tamper clears; i_srst is deliberately absent
  generate
    for (gi = 0; gi < `BKPTD_WORDS; gi++) begin : g_word
      always_ff @(posedge i_clock) begin
        if (backup_domain_rst || tamper_event || tamper_event_flag_reg) begin
          data_reg[gi] <= `BKPTD_WORD_RESET;
        end else if (write_done && data_hit[gi]) begin
          data_reg[gi] <= i_pwdata[15:0];
        end
      end
    end
  endgenerate

  //------------------------------------------------------------------
  // outputs
  //------------------------------------------------------------------
  // irq is a level to the interrupt controller only; no wake-up path exists
  assign o_tamper_irq = tamper_irq_flag_reg;
  assign o_tamper_detect_enable = tamper_detect_enable_reg;
  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;

  //------------------------------------------------------------------
  // assertions
  //------------------------------------------------------------------
  // all checks run on the one clock; system reset masks them
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);

  AST_WORDS_ZERO_WHILE_EVENT: assert property (
    tamper_event_flag_reg |-> (data_reg[0] == 16'h0000 && data_reg[41] == 16'h0000))
    else $error("backup word nonzero while event flag set");

  AST_WRITE_DROPPED: assert property (
    (write_done && data_hit[2] && tamper_event_flag_reg) |=> data_reg[2] == 16'h0000)
    else $error("write stored while event flag set");

  AST_WRITE_STORED: assert property (
    (write_done && data_hit[3] && !tamper_event_flag_reg && !tamper_event &&
     !backup_domain_rst) |=> data_reg[3] == $past(i_pwdata[15:0]))
    else $error("payload write not stored");

  AST_SPURIOUS_EVENT: assert property (
    (spurious_event && !backup_domain_rst) |=> tamper_event_flag_reg)
    else $error("clearing both control bits raised no event");

  AST_IRQ_NEEDS_ENABLE: assert property (
    $rose(tamper_irq_flag_reg) |-> ($past(tamper_irq_enable_reg) && $past(tamper_event) &&
      $past(tamper_detect_enable_reg)))
    else $error("irq flag rose without enabled event");

  AST_IRQ_EN_CLEAR: assert property (
    (wr_csts && !i_pwdata[2] && !tamper_event) |=> !tamper_irq_flag_reg)
    else $error("irq flag survived enable clear");

  AST_EVENT_STICKY: assert property (
    (tamper_event_flag_reg && !wr_csts && !backup_domain_rst) |=> tamper_event_flag_reg)
    else $error("event flag dropped without clear");

  AST_DETECT_LATENCY: assert property (
    (tamper_detect_enable_reg && !tamper_active_level_reg && !backup_domain_rst &&
     i_tamper_pin && !tamper_event_flag_reg)[*6] |-> ##[0:1] tamper_event_flag_reg)
    else $error("held active level not detected");

  AST_PREADY_ONE_CYCLE: assert property (
    (i_psel && !i_penable) |=> (o_pready ##1 !o_pready))
    else $error("apb answer timing broken");

  AST_BDRST_CLEARS: assert property (
    backup_domain_rst |=> (!tamper_event_flag_reg || $past(tamper_event)) &&
      !tamper_detect_enable_reg)
    else $error("backup domain reset did not clear state");

  // register-side checks; read data is looked at in the access cycle
  AST_WORDS_SURVIVE_WAKE: assert property (
    (i_standby_wake && !backup_domain_rst && !tamper_event && !tamper_event_flag_reg &&
     !write_done) |=> $stable(data_reg[4]))
    else $error("backup word changed on standby wake");

  AST_WAKE_CLEARS_IRQ: assert property (
    i_standby_wake |=> (!tamper_irq_flag_reg && !tamper_irq_enable_reg))
    else $error("standby wake left irq state set");

  AST_BDRST_KEEPS_IRQ: assert property (
    (backup_domain_rst && !sys_rst && !wr_csts) |=> $stable(tamper_irq_enable_reg))
    else $error("backup domain reset touched irq enable");

  AST_BDRST_WORDS: assert property (
    backup_domain_rst |=> (data_reg[9] == 16'h0000 && data_reg[30] == 16'h0000))
    else $error("backup domain reset left a word set");

  AST_NO_HIT_DISABLED: assert property (
    !tamper_detect_enable_reg |=> !detector_hit)
    else $error("detector hit while detection disabled");

  AST_IRQ_NEEDS_DETECT: assert property (
    (!tamper_detect_enable_reg && !tamper_irq_flag_reg) |=> !tamper_irq_flag_reg)
    else $error("irq flag set with detection disabled");

  AST_EVENT_CLEAR: assert property (
    (wr_csts && i_pwdata[`BKPTD_CSTS_CLR_EVENT_BIT] && !tamper_event && !backup_domain_rst)
      |=> !tamper_event_flag_reg)
    else $error("event flag survived its clear");

  AST_IRQ_CLEAR: assert property (
    (wr_csts && i_pwdata[`BKPTD_CSTS_CLR_IRQ_BIT] && !tamper_event) |=> !tamper_irq_flag_reg)
    else $error("irq flag survived its clear");

  AST_CSTS_READ_ZERO: assert property (
    (setup_phase && !i_pwrite && sel == bkptd_pkg::BKPTD_SEL_CSTS) |=>
      (o_prdata[1:0] == 2'h0 && o_prdata[31:10] == 22'h0))
    else $error("write-only or reserved status bits read nonzero");

  AST_UPPER_READ_ZERO: assert property (
    o_pready |-> o_prdata[31:16] == 16'h0000)
    else $error("upper read bits nonzero");

  AST_UNMAPPED_ERROR: assert property (
    (setup_phase && sel == bkptd_pkg::BKPTD_SEL_NONE) |=>
      (o_pslverr && o_prdata == 32'h00000000))
    else $error("unmapped access not refused");

  AST_DETECT_LOW_LEVEL: assert property (
    (tamper_detect_enable_reg && tamper_active_level_reg && !backup_domain_rst &&
     !i_tamper_pin && !tamper_event_flag_reg)[*6] |-> ##[0:1] tamper_event_flag_reg)
    else $error("held low level not detected");

  COV_TAMPER_EVENT: cover property (detector_hit ##1 tamper_event_flag_reg);
  COV_IRQ_RAISED: cover property ($rose(tamper_irq_flag_reg));
  COV_EVENT_CLEARED: cover property (tamper_event_flag_reg ##1 !tamper_event_flag_reg);
  COV_SPURIOUS: cover property (spurious_event);
  COV_LOW_LEVEL_EVENT: cover property (tamper_active_level_reg && detector_hit);
endmodule

// [shared/bkptd_cfg.svh]
//------------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------------
// Overview of operation
// - 42 backup words, 16-bit user payload in low bits, read and write.
// - backup words survive system reset, power reset and standby wake-up; here a system reset with detection on fakes an event that clears them.
// - backup words clear on backup domain reset or enabled tamper event.
// - control bit 1 picks active level: 0 high is tamper, 1 low is tamper.
// - control bit 0 enables detection; when 0 the pin is plain GPIO.
// - setting both control bits is safe; clearing both gives false tamper event.
// - status bit 9 irq flag sets on tamper event while irq enable is 1.
// - irq flag also clears whenever irq enable is cleared; here an event in that same cycle sets it instead.
// - irq flag and irq enable reset only by system reset or standby wake.
// - status bit 8 event flag sets on each event, held until cleared.
// - tamper event clears all words; they stay zero while event flag is 1.
// - writes to backup words are dropped while the event flag is 1.
// - status bit 2 enables irq; effective only with detection enabled.
// - tamper interrupt never acts as a low-power wake-up source.
// - bit 1 write-only, reads 0; writing 1 clears irq request and flag.
// - bit 0 write-only, reads 0; writing 1 clears event flag, rearms detector.
// - backup domain reset from soft-reset bit or supply return after full loss.
`ifndef BKPTD_CFG_SVH
`define BKPTD_CFG_SVH

//------------------------------------------------------------------
// register map
//------------------------------------------------------------------
`define BKPTD_ADDR_W 8
`define BKPTD_WORDS 42
`define BKPTD_LO_WORDS 10
`define BKPTD_DATA_LO_BASE 8'h04
`define BKPTD_DATA_HI_BASE 8'h40
`define BKPTD_CTRL_OFFSET 8'h30
`define BKPTD_CSTS_OFFSET 8'h34

//------------------------------------------------------------------
// field positions and reset values
//------------------------------------------------------------------
`define BKPTD_CTRL_EN_BIT 0
`define BKPTD_CTRL_ALEV_BIT 1
`define BKPTD_CSTS_CLR_EVENT_BIT 0
`define BKPTD_CSTS_CLR_IRQ_BIT 1
`define BKPTD_CSTS_IRQ_EN_BIT 2
`define BKPTD_CSTS_EVENT_FLAG_BIT 8
`define BKPTD_CSTS_IRQ_FLAG_BIT 9
`define BKPTD_WORD_RESET 16'h0000
`define BKPTD_BIT_RESET 1'b0

`endif

// [shared/bkptd_pkg.sv]
package bkptd_pkg;
  // one user payload word
  typedef logic [15:0] bkptd_word_type;
  // which register an address decodes to
  typedef enum logic [1:0] {
    BKPTD_SEL_NONE = 2'h0,
    BKPTD_SEL_DATA = 2'h1,
    BKPTD_SEL_CTRL = 2'h3,
    BKPTD_SEL_CSTS = 2'h2
  } bkptd_sel_type;
endpackage

// [verification/bkptd_pin_model.sv]
`timescale 1ns/1ns
//------------------------------------------------------------------
// enclosure switch on the tamper pin
//------------------------------------------------------------------
module bkptd_pin_model (
  input wire logic i_clock,
  input wire logic i_attack,
  input wire logic i_active_low,
  output logic o_tamper_pin
);
  // the pin moves one edge after the request, on the same clock as the detector
  initial o_tamper_pin = 1'b0;
  always @(posedge i_clock) begin
    o_tamper_pin <= i_attack ^ i_active_low;
  end
endmodule

// [verification/bkptd_top_bench.sv]
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
//------------------------------------------------------------------
// bench top
//------------------------------------------------------------------
module bkptd_top_bench;
  logic clk = 1'b0, srst = 1'b1, wake = 1'b0, bd_rst = 1'b1, supply = 1'b0;
  logic pin, attack = 1'b0, active_low = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, seed = 32'h2979;
  logic pready, pslverr, irq, tde;
  logic [32:0] exp_q[$];
  logic [15:0] mem[1:42];
  logic [31:0] bad[5] = '{32'h2c, 32'h38, 32'hc0, 32'h06, 32'h100};
  int n_mismatch = 0, tests_run = 0;

  // 20 MHz clock
  always #25 clk = ~clk;

  bkptd_top DUT (.i_clock(clk), .i_srst(srst), .i_standby_wake(wake),
    .i_backup_domain_soft_reset(bd_rst), .i_supply_return(supply), .i_tamper_pin(pin),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_tamper_irq(irq), .o_tamper_detect_enable(tde));

  bkptd_pin_model far_side (.i_clock(clk), .i_attack(attack), .i_active_low(active_low),
    .o_tamper_pin(pin));

  //------------------------------------------------------------------
  // helpers
  //------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] waddr(input int k);
    return (k <= 10) ? 32'(4 * k) : 32'(64 + 4 * (k - 11));
  endfunction

  task automatic final_report;
    if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // one apb transfer; the answer is noted for the monitor before it can appear
  task automatic xfer(input logic w, input logic [31:0] a, d, e, input logic err);
    int n;
    n = 0;
    exp_q.push_back({err, e});
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) n_mismatch++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, d);
    xfer(1'b1, a, d, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [31:0] a, e);
    xfer(1'b0, a, 32'h0, e, 1'b0);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // bounded wait for the interrupt flag pin
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    `CHK("tamper irq", 1'b1, irq)
  endtask

  // monitor: every completed transfer retires the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      `CHK("apb response", exp_q.pop_front(), {pslverr, prdata})
    end
  end

  // watchdog, far beyond the ~520 cycles the sequence needs
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    final_report();
  end

  //------------------------------------------------------------------
  // main sequence; control and status reserved bits are always written as zero
  //------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    bd_rst <= 1'b0;
    rd(32'h30, 32'h0);
    rd(32'h34, 32'h0);
    rd(waddr(1), 32'h0);
    for (int k = 1; k <= 42; k++) begin
      seed = lfsr(seed);
      mem[k] = seed[15:0];
      wr(waddr(k), seed);
    end
    for (int k = 1; k <= 42; k++) rd(waddr(k), {16'h0, mem[k]});
    foreach (bad[i]) begin
      xfer(1'b0, bad[i], 32'h0, 32'h0, 1'b1);
      xfer(1'b1, bad[i], 32'hffff, 32'h0, 1'b1);
    end
    // system reset and standby wake must leave the payload alone
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      if (i == 0) srst <= 1'b1;
      else wake <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      wake <= 1'b0;
      rd(waddr(5 + i), {16'h0, mem[5 + i]});
    end
    // detection off: an active pin is just an input, even with the irq enabled
    wr(32'h34, 32'h4);
    attack <= 1'b1;
    wait_cyc(10);
    rd(waddr(7), {16'h0, mem[7]});
    rd(32'h34, 32'h4);
    `CHK("tamper irq", 1'b0, irq)
    attack <= 1'b0;
    // high-level tamper with the interrupt enabled
    wr(32'h34, 32'h4);
    wr(32'h30, 32'h1);
    wait_cyc(1);
    `CHK("detect enable", 1'b1, tde)
    attack <= 1'b1;
    wait_irq();
    rd(32'h34, 32'h304);
    rd(waddr(42), 32'h0);
    wr(waddr(3), 32'h1234);
    rd(waddr(3), 32'h0);
    attack <= 1'b0;
    wait_cyc(10);
    rd(waddr(3), 32'h0);
    wr(32'h34, 32'h5);
    rd(32'h34, 32'h204);
    wr(waddr(3), 32'hbeef);
    rd(waddr(3), 32'hbeef);
    wr(32'h34, 32'h6);
    rd(32'h34, 32'h4);
    `CHK("tamper irq", 1'b0, irq)
    // low-level tamper; the level bit changes only while detection is off
    // the switch's new idle level must clear the synchroniser before enabling
    wr(32'h30, 32'h0);
    active_low <= 1'b1;
    wait_cyc(10);
    wr(32'h30, 32'h3);
    wait_cyc(10);
    rd(32'h34, 32'h4);
    attack <= 1'b1;
    wait_irq();
    attack <= 1'b0;
    wait_cyc(10);
    wr(32'h34, 32'h0);
    rd(32'h34, 32'h100);
    `CHK("tamper irq", 1'b0, irq)
    wr(32'h34, 32'h5);
    attack <= 1'b1;
    wait_irq();
    attack <= 1'b0;
    wait_cyc(10);
    // supply return clears the backup domain but not the irq state
    @(posedge clk);
    supply <= 1'b1;
    @(posedge clk);
    supply <= 1'b0;
    rd(32'h34, 32'h204);
    rd(32'h30, 32'h0);
    rd(waddr(9), 32'h0);
    `CHK("tamper irq", 1'b1, irq)
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    wait_cyc(1);
    `CHK("tamper irq", 1'b0, irq)
    rd(32'h34, 32'h0);
    // dropping both control bits in one write is a false event
    wr(32'h34, 32'h4);
    wr(32'h30, 32'h3);
    wait_cyc(10);
    rd(32'h34, 32'h4);
    wr(32'h30, 32'h0);
    wait_cyc(10);
    // the false event is a full event: detection was still on, so the irq fires
    rd(32'h34, 32'h304);
    `CHK("tamper irq", 1'b1, irq)
    final_report();
  end
endmodule
